// File: core/sswc_ctrl.sv
/*
 * Supply sleep and wake-up controller: gates the main supply output and three auxiliary
 * supply and ground switches, times the sleep state and detects wake-up pin edges.
 * Assumes a byte register port already decoded from the serial interface, synchronous inputs,
 * and a comparator flag telling that storage is above the release threshold.
 */
`timescale 1ns/100ps
module sswc_ctrl (
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       storage_above_release_i,
    input  wire logic       wake_pin_i,
    output logic            main_supply_on_o,
    output logic            main_supply_ground_o,
    output logic      [2:0] aux_output_enable_o,
    output logic      [2:0] aux_ground_enable_o,
    output logic            sda_slope_fast_o
);
    localparam int TW = $clog2(sswc_pkg::TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(sswc_pkg::TICK_CYCLES - 1);
    localparam logic [2:0] DEB_LAST = 3'(sswc_pkg::DEB_SAMPLES - 1);

    function automatic logic edge_match(input logic [1:0] sel, input logic prev,
                                        input logic cur);
        edge_match = (sel[1] && !prev && cur) || (sel[0] && prev && !cur);
    endfunction

    sswc_pkg::sswc_state_t state_r, state_nxt;
    logic [7:0]  wake_cfg_r, wake_cfg_nxt;
    logic [7:0]  pwr_en_r, pwr_en_nxt;
    logic [7:0]  supply_cfg_r, supply_cfg_nxt;
    logic [23:0] sleep_len_r, sleep_len_nxt;
    logic [23:0] ms_cnt_r, ms_cnt_nxt;
    logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [2:0]  aux_hold_r, aux_hold_nxt;
    logic        pin_r, pin_nxt;
    logic        deb_r, deb_nxt;
    logic [2:0]  deb_cnt_r, deb_cnt_nxt;
    logic        level_r, level_nxt;
    logic [7:0]  rdata_nxt;
    logic        main_on_nxt, main_gnd_nxt;
    logic        slope_nxt;
    logic [2:0]  aux_out_nxt, aux_gnd_nxt;
    logic        sleeping, level_now, wake_evt, timeout, acc_ok;

    function automatic logic [2:0] aux_out_nxt_live();
        aux_out_nxt_live = storage_above_release_i ?
                           pwr_en_r[sswc_pkg::BIT_AUX_LO +: 3] : 3'h0;
    endfunction

    assign sleeping  = (state_r == sswc_pkg::SSWC_ASLEEP);
    // The debounced and raw paths share one edge detector so switching the filter cannot
    // fabricate an edge beyond a single level difference.
    assign level_now = wake_cfg_r[sswc_pkg::BIT_DEB_EN] ? deb_r : pin_r;
    assign wake_evt  = sleeping &&
        edge_match(wake_cfg_r[sswc_pkg::BIT_EDGE_LO +: 2], level_r, level_now);
    // A programmed count of zero ends the nap at the first millisecond, like a count of one.
    assign timeout   = sleeping && (tick_cnt_r == TICK_LAST) &&
                       (ms_cnt_r + 24'h000001 >= sleep_len_r);
    // Reads while asleep answer zero rather than stale data, so a poll cannot mistake them.
    assign acc_ok    = !sleeping;

    // Wake-up pin sampling and debounce.
    always_comb begin
        pin_nxt     = wake_pin_i;
        deb_nxt     = deb_r;
        // Any return to the settled level restarts the count, so a short glitch is dropped.
        deb_cnt_nxt = 3'h0;
        if (pin_r != deb_r) begin
            deb_cnt_nxt = deb_cnt_r + 3'h1;
            if (deb_cnt_r == DEB_LAST) begin
                deb_nxt     = pin_r;
                deb_cnt_nxt = 3'h0;
            end
        end
        level_nxt = level_now;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_r     <= 1'b0;
            deb_r     <= 1'b0;
            deb_cnt_r <= 3'h0;
            level_r   <= 1'b0;
        end else begin
            pin_r     <= pin_nxt;
            deb_r     <= deb_nxt;
            deb_cnt_r <= deb_cnt_nxt;
            level_r   <= level_nxt;
        end
    end

    // Registers, sleep state and timer.
    always_comb begin
        state_nxt      = state_r;
        wake_cfg_nxt   = wake_cfg_r;
        pwr_en_nxt     = pwr_en_r;
        supply_cfg_nxt = supply_cfg_r;
        sleep_len_nxt  = sleep_len_r;
        ms_cnt_nxt     = ms_cnt_r;
        tick_cnt_nxt   = tick_cnt_r;
        aux_hold_nxt   = aux_hold_r;
        rdata_nxt      = 8'h00;
        if (reg_wr_i && acc_ok) begin
            case (reg_addr_i)
                sswc_pkg::ADDR_WAKE_CFG:   wake_cfg_nxt = reg_wdata_i;
                sswc_pkg::ADDR_SLEEP_LO:   sleep_len_nxt[7:0] = reg_wdata_i;
                sswc_pkg::ADDR_SLEEP_MID:  sleep_len_nxt[15:8] = reg_wdata_i;
                sswc_pkg::ADDR_SLEEP_HI:   sleep_len_nxt[23:16] = reg_wdata_i;
                sswc_pkg::ADDR_SUPPLY_CFG: supply_cfg_nxt = reg_wdata_i;
                // Bit 7 is kept at zero regardless of what software writes.
                sswc_pkg::ADDR_PWR_EN:     pwr_en_nxt = {1'b0, reg_wdata_i[6:0]};
                default:                   pwr_en_nxt = pwr_en_r;
            endcase
        end
        if (reg_rd_i && acc_ok) begin
            case (reg_addr_i)
                sswc_pkg::ADDR_WAKE_CFG:   rdata_nxt = wake_cfg_r;
                sswc_pkg::ADDR_SLEEP_LO:   rdata_nxt = sleep_len_r[7:0];
                sswc_pkg::ADDR_SLEEP_MID:  rdata_nxt = sleep_len_r[15:8];
                sswc_pkg::ADDR_SLEEP_HI:   rdata_nxt = sleep_len_r[23:16];
                sswc_pkg::ADDR_SUPPLY_CFG: rdata_nxt = supply_cfg_r;
                sswc_pkg::ADDR_PWR_EN:     rdata_nxt = pwr_en_r;
                default:                   rdata_nxt = 8'h00;
            endcase
        end
        case (state_r)
            sswc_pkg::SSWC_AWAKE: begin
                // The held copy tracks the live enables while awake, so entry costs no cycle.
                aux_hold_nxt = aux_out_nxt_live();
                if (pwr_en_r[sswc_pkg::BIT_SLEEP]) begin
                    state_nxt    = sswc_pkg::SSWC_ASLEEP;
                    ms_cnt_nxt   = 24'h000000;
                    tick_cnt_nxt = '0;
                end
            end
            sswc_pkg::SSWC_ASLEEP: begin
                tick_cnt_nxt = (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
                if (tick_cnt_r == TICK_LAST) begin
                    ms_cnt_nxt = ms_cnt_r + 24'h000001;
                end
                if (timeout || wake_evt) begin
                    state_nxt = sswc_pkg::SSWC_AWAKE;
                    pwr_en_nxt[sswc_pkg::BIT_SLEEP] = 1'b0;
                    ms_cnt_nxt   = 24'h000000;
                    tick_cnt_nxt = '0;
                end
            end
            default: state_nxt = sswc_pkg::SSWC_AWAKE;
        endcase
    end

    always_comb begin
        main_on_nxt  = !sleeping && !(pwr_en_r[sswc_pkg::BIT_SLEEP]);
        main_gnd_nxt = !main_on_nxt && supply_cfg_r[sswc_pkg::BIT_TIE_LOW];
        aux_out_nxt  = sleeping ? aux_hold_r : aux_out_nxt_live();
        aux_gnd_nxt  = storage_above_release_i ?
                       pwr_en_r[sswc_pkg::BIT_GND_LO +: 3] : 3'h0;
        slope_nxt    = wake_cfg_r[sswc_pkg::BIT_SLOPE];
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r              <= sswc_pkg::SSWC_AWAKE;
            wake_cfg_r           <= sswc_pkg::WAKE_CFG_RST;
            pwr_en_r             <= sswc_pkg::PWR_EN_RST;
            supply_cfg_r         <= sswc_pkg::SUPPLY_CFG_RST;
            sleep_len_r          <= sswc_pkg::SLEEP_CNT_RST;
            ms_cnt_r             <= 24'h000000;
            tick_cnt_r           <= '0;
            aux_hold_r           <= 3'h0;
            reg_rdata_o          <= 8'h00;
            main_supply_on_o     <= 1'b0;
            main_supply_ground_o <= 1'b0;
            aux_output_enable_o  <= 3'h0;
            aux_ground_enable_o  <= 3'h0;
            sda_slope_fast_o     <= 1'b0;
        end else begin
            state_r              <= state_nxt;
            wake_cfg_r           <= wake_cfg_nxt;
            pwr_en_r             <= pwr_en_nxt;
            supply_cfg_r         <= supply_cfg_nxt;
            sleep_len_r          <= sleep_len_nxt;
            ms_cnt_r             <= ms_cnt_nxt;
            tick_cnt_r           <= tick_cnt_nxt;
            aux_hold_r           <= aux_hold_nxt;
            reg_rdata_o          <= rdata_nxt;
            main_supply_on_o     <= main_on_nxt;
            main_supply_ground_o <= main_gnd_nxt;
            aux_output_enable_o  <= aux_out_nxt;
            aux_ground_enable_o  <= aux_gnd_nxt;
            sda_slope_fast_o     <= slope_nxt;
        end
    end
endmodule

// File: core/sswc_pkg.sv
/*
 * Package for the supply sleep and wake-up controller: register offsets, field positions,
 * default values and timing counts.
 * Assumes a 50 MHz core clock and a byte-wide register port.
 */
package sswc_pkg;
    localparam logic [7:0] ADDR_WAKE_CFG   = 8'h13;
    localparam logic [7:0] ADDR_SLEEP_LO   = 8'h14;
    localparam logic [7:0] ADDR_SLEEP_MID  = 8'h15;
    localparam logic [7:0] ADDR_SLEEP_HI   = 8'h16;
    localparam logic [7:0] ADDR_PWR_EN     = 8'h19;
    localparam logic [7:0] ADDR_SUPPLY_CFG = 8'h0E;
    localparam logic [7:0] ADDR_AUX_CFG    = 8'h10;
    localparam logic [7:0] ADDR_AUXGND_CFG = 8'h11;

    localparam int BIT_SLEEP      = 0;
    localparam int BIT_AUX_LO     = 1;
    localparam int BIT_GND_LO     = 4;
    localparam int BIT_PWR_RSVD   = 7;
    localparam int BIT_TIE_LOW    = 7;
    localparam int BIT_SLOPE      = 7;
    localparam int BIT_DEB_EN     = 6;
    localparam int BIT_EDGE_LO    = 4;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [7:0] WAKE_CFG_RST   = 8'h70;
    localparam logic [7:0] PWR_EN_RST     = 8'h00;
    localparam logic [7:0] SUPPLY_CFG_RST = 8'h00;
    localparam logic [7:0] AUX_CFG_RST    = 8'h00;
    localparam logic [7:0] AUXGND_CFG_RST = 8'h00;
    localparam logic [23:0] SLEEP_CNT_RST = 24'h0003E8;

    localparam int CLK_HZ       = 50000000;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;
    localparam int DEB_SAMPLES  = 4;

    typedef enum logic [1:0] {
        SSWC_AWAKE  = 2'b01,
        SSWC_ASLEEP = 2'b10
    } sswc_state_t;
endpackage

// File: tb/sswc_app_model.sv
/* Wake-up pin driver on the application side.
   Assumes the bench calls hold; the pin changes just after a rising edge. */
`timescale 1ns/100ps
module sswc_app_model (
    input  wire logic core_clk_i,
    output logic      wake_pin_o
);
    initial wake_pin_o = 1'b0;
    task automatic hold(input logic lvl, input int n);
        @(posedge core_clk_i) wake_pin_o <= lvl;
        repeat (n) @(posedge core_clk_i);
    endtask
endmodule

// File: tb/sswc_ctrl_sva.sv
/* Port checker for sswc_ctrl.
   Assumes it is bound to every sswc_ctrl instance. */
`timescale 1ns/100ps
module sswc_ctrl_sva (
    input wire logic       core_clk_i,
    input wire logic       arst_n_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       storage_above_release_i,
    input wire logic       main_supply_on_o,
    input wire logic       main_supply_ground_o,
    input wire logic [2:0] aux_output_enable_o,
    input wire logic [2:0] aux_ground_enable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_sleep_entry: assert property (reg_wr_i && reg_addr_i == 8'h19 && reg_wdata_i[0]
        && main_supply_on_o |-> ##3 !main_supply_on_o) else $error("sleep not entered");
    a_ground_when_off: assert property (
        main_supply_ground_o |-> !main_supply_on_o) else $error("grounded while on");
    a_aux_frozen: assert property (!$past(main_supply_on_o) && !main_supply_on_o
        |-> $stable(aux_output_enable_o)) else $error("aux moved in sleep");
    a_reads_blocked: assert property (!$past(main_supply_on_o) && !main_supply_on_o
        |-> reg_rdata_o == 8'h00) else $error("read data in sleep");
    a_aux_gated: assert property (main_supply_on_o && $past(main_supply_on_o)
        && !$past(storage_above_release_i) |-> aux_output_enable_o == 3'h0) else $error("aux on");
    a_gnd_gated: assert property (!$past(storage_above_release_i)
        |-> aux_ground_enable_o == 3'h0) else $error("ground switch on");
    a_rdata_idle: assert property (!$past(reg_rd_i)
        |-> reg_rdata_o == 8'h00) else $error("read data without read");
    a_top_bit_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h19
        |-> !reg_rdata_o[7]) else $error("top bit set");
endmodule
bind sswc_ctrl sswc_ctrl_sva chk_u (.core_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .storage_above_release_i, .main_supply_on_o,
    .main_supply_ground_o, .aux_output_enable_o, .aux_ground_enable_o);

// File: tb/tb_top.sv
/* Self-checking bench for sswc_ctrl: registers, storage gating, sleep timeout, wake-up.
   Assumes a 50 MHz clock, so the 1 ms sleep used here lasts 50000 cycles. */
`timescale 1ns/100ps
module tb_top;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} sswc_row_t;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, st = 1'b1;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic       on, gnd, slope, pin;
    logic [2:0] aux, agnd;
    int         fail_count = 0, checks_done = 0, n;
    // Reset values first, then writes read back; the middle count byte is cleared so that
    // the timed nap below lasts exactly one millisecond.
    sswc_row_t  rows[11] = '{'{1'h0, 8'h13, 8'h00, 8'h70}, '{1'h0, 8'h14, 8'h00, 8'hE8},
        '{1'h0, 8'h15, 8'h00, 8'h03}, '{1'h0, 8'h16, 8'h00, 8'h00},
        '{1'h0, 8'h19, 8'h00, 8'h00}, '{1'h1, 8'h19, 8'h7E, 8'h7E},
        '{1'h1, 8'h14, 8'h01, 8'h01}, '{1'h1, 8'h15, 8'h00, 8'h00},
        '{1'h1, 8'h0E, 8'h80, 8'h80}, '{1'h1, 8'h20, 8'h55, 8'h00},
        '{1'h1, 8'h13, 8'hF0, 8'hF0}};
    always #10 clk = ~clk;
    sswc_ctrl dut_u (.core_clk_i(clk), .arst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .storage_above_release_i(st),
        .wake_pin_i(pin), .main_supply_on_o(on), .main_supply_ground_o(gnd),
        .aux_output_enable_o(aux), .aux_ground_enable_o(agnd), .sda_slope_fast_o(slope));
    sswc_app_model app_u (.core_clk_i(clk), .wake_pin_o(pin));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) rd <= 1'b1;
        addr <= a;
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) chk(rdata, e);
    endtask
    task automatic nap();
        wr8(8'h19, 8'h01);
        repeat (2) @(posedge clk);
        @(negedge clk) chk({6'h0, on, gnd}, 8'h00);
    endtask
    task automatic wait_on(input int lim, output int c);
        c = 0;
        while (on !== 1'b1 && c < lim) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20 * 80000);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr8(rows[i].a, rows[i].d);
            rd8(rows[i].a, rows[i].e);
        end
        chk({slope, aux, agnd, gnd}, 8'hFE);
        @(posedge clk) st <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) chk({2'h0, aux, agnd}, 8'h00);
        @(posedge clk) st <= 1'b1;
        $display("test registers done");
        wr8(8'h19, 8'h7F);
        repeat (2) @(posedge clk);
        @(negedge clk) chk({6'h0, on, gnd}, 8'h01);
        rd8(8'h14, 8'h00);
        wr8(8'h14, 8'h55);
        @(posedge clk) st <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) chk({2'h0, aux, agnd}, 8'h38);
        @(posedge clk) st <= 1'b1;
        wait_on(60000, n);
        chk({7'h0, n > 49900 && n < 50010}, 8'h01);
        rd8(8'h19, 8'h7E);
        rd8(8'h14, 8'h01);
        $display("test timeout done");
        wr8(8'h0E, 8'h00);
        for (int c = 1; c < 4; c++) begin
            wr8(8'h13, {2'h1, c[1:0], 4'h0});
            app_u.hold(c == 1, 8);
            nap();
            app_u.hold(c != 1, 0);
            wait_on(20, n);
            chk({7'h0, on}, 8'h01);
        end
        wr8(8'h13, 8'h60);
        app_u.hold(1'b1, 8);
        nap();
        app_u.hold(1'b0, 0);
        app_u.hold(1'b1, 20);
        @(negedge clk) chk({7'h0, on}, 8'h00);
        app_u.hold(1'b0, 20);
        @(negedge clk) chk({7'h0, on}, 8'h00);
        app_u.hold(1'b1, 0);
        wait_on(20, n);
        chk({7'h0, on}, 8'h01);
        wr8(8'h13, 8'h20);
        app_u.hold(1'b0, 8);
        nap();
        app_u.hold(1'b1, 0);
        app_u.hold(1'b0, 0);
        wait_on(20, n);
        chk({7'h0, on}, 8'h01);
        $display("test wake-up done");
        // A reset in mid-nap must drop every output and bring the defaults back.
        wr8(8'h0E, 8'h80);
        wr8(8'h13, 8'hB0);
        wr8(8'h19, 8'h01);
        repeat (2) @(posedge clk);
        @(negedge clk) chk({5'h0, slope, on, gnd}, 8'h05);
        @(posedge clk) rst_n <= 1'b0;
        @(negedge clk) chk({2'h0, slope, on, gnd, aux}, 8'h00);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) chk({5'h0, slope, on, gnd}, 8'h02);
        rd8(8'h13, 8'h70);
        rd8(8'h19, 8'h00);
        $display("test reset done");
        test_done();
    end
endmodule
